// ---- common/ppp_pkg.sv ----
// shared constants and types for the 8-bit PHY lane port
// Functional notes
// - core drives two-bit power-state request
// - link reset input is active low
// - all link signals timed by PHY clock
// - optional source-synchronous transmit clock output
// - per lane transmit byte plus K flag
// - per lane receive polarity invert control
// - per lane transmit compliance control
// - per lane transmit electrical idle control
// - lane 0 always; lanes 1-3 x4 only
package ppp_pkg;

  // lane configuration
  localparam int PPP_MAX_LANES = 4;
  localparam int PPP_ADDR_W    = 8;

  // register byte offsets
  localparam logic [7:0] PPP_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PPP_STATUS_OFS = 8'h04;
  localparam logic [7:0] PPP_LANE_OFS   = 8'h08;
  localparam logic [3:0] PPP_TX_REGION  = 4'h1;  // 0x10 + 4*lane
  localparam logic [3:0] PPP_RX_REGION  = 4'h2;  // 0x20 + 4*lane

  // control register fields
  localparam int PPP_CTRL_PWR_LSB = 0;

  // status register fields
  localparam int PPP_ST_BUSY     = 0;
  localparam int PPP_ST_DONE     = 1;
  localparam int PPP_ST_REFUSED  = 2;
  localparam int PPP_ST_LINK_RST = 3;
  localparam int PPP_ST_PWR_LSB  = 4;
  localparam int PPP_ST_PHYDONE  = 6;
  localparam int PPP_ST_IDLE_LSB = 8;
  localparam int PPP_ST_VLD_LSB  = 12;

  // lane control register fields
  localparam int PPP_LC_INV_LSB  = 0;
  localparam int PPP_LC_CMP_LSB  = 4;
  localparam int PPP_LC_IDLE_LSB = 8;

  // reset values
  localparam logic [1:0] PPP_PWR_RST     = 2'h2;
  localparam logic       PPP_TX_IDLE_RST = 1'b1;

  // PHY clock rates in MHz
  localparam int PPP_PCLK_SDR_MHZ = 250;
  localparam int PPP_PCLK_DDR_MHZ = 125;

  // transmit word of one lane
  typedef struct packed {
    logic [7:0] data;
    logic       kchar;
  } ppp_tx_s;

  // receive word of one lane
  typedef struct packed {
    logic [7:0] data;
    logic       kchar;
    logic [1:0] status;
    logic       valid;
    logic       idle;
  } ppp_rx_s;

  // power request sequencer
  typedef enum logic [1:0] {
    PWR_IDLE,
    PWR_LAUNCH,
    PWR_WAIT
  } ppp_pwr_e;

endpackage : ppp_pkg

// ---- hdl/ppp_lane.sv ----
// one lane: receive sampling and transmit launch on PHY clock edges
`timescale 1ns/100ps
module ppp_lane
  import ppp_pkg::*;
(
  // clock and reset
  input  wire logic    clk,
  input  wire logic    rst,
  input  wire logic    ce,
  // link timing
  input  wire logic    link_up,
  input  wire logic    pclk_rise,
  // core side
  input  wire ppp_tx_s tx_word,
  input  wire logic    invert,
  input  wire logic    compliance,
  input  wire logic    idle_req,
  output ppp_rx_s      rx_cap,
  // pin side
  input  wire ppp_rx_s rx_pin,
  output ppp_tx_s      tx_pin,
  output logic         invert_pin,
  output logic         compl_pin,
  output logic         idle_pin
);

  // all lane state
  typedef struct packed {
    ppp_rx_s rx_s1;  // first sync stage, read only by rx_s2
    ppp_rx_s rx_s2;
    ppp_rx_s rx_s3;  // value seen just before the edge
    ppp_rx_s cap;
    ppp_tx_s tx;
    logic    inv;
    logic    cmp;
    logic    idl;
  } ppp_lane_s;

  ppp_lane_s q;  // registered state
  ppp_lane_s d;  // next state

  // next-state logic
  always_comb
  begin
    d       = q;
    d.rx_s1 = rx_pin;
    d.rx_s2 = q.rx_s1;
    d.rx_s3 = q.rx_s2;
    if (!link_up)
    begin
      // link reset: quiet transmitter, clear capture
      d.cap = '0;
      d.tx  = '0;
      d.inv = 1'b0;
      d.cmp = 1'b0;
      d.idl = PPP_TX_IDLE_RST;
    end
    else if (pclk_rise)
    begin
      // pre-edge value avoids racing the PHY's own launch
      d.cap = q.rx_s3;
      d.tx  = tx_word;
      d.inv = invert;
      d.cmp = compliance;
      d.idl = idle_req;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q     <= '0;
      q.idl <= PPP_TX_IDLE_RST;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign rx_cap     = q.cap;
  assign tx_pin     = q.tx;
  assign invert_pin = q.inv;
  assign compl_pin  = q.cmp;
  assign idle_pin   = q.idl;

endmodule : ppp_lane

// ---- hdl/ppp_port.sv ----
// controller-side 8-bit PHY lane port with APB register access
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module ppp_port
  import ppp_pkg::*;
#(
  parameter int   LANES     = 4,     // 1 or 4
  parameter logic HAS_TXCLK = 1'b1   // drive the transmit clock
)
(
  // core clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  CLK_EN,
  // apb slave
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [PPP_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]           PWDATA,
  input  wire logic [3:0]            PSTRB,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // shared link signals
  input  wire logic                  PHY_CLK,
  input  wire logic                  LINK_RST_N,
  input  wire logic                  PHY_DONE,
  output logic      [1:0]            POWER_REQUEST,
  output logic                       TX_CLK_OUT,
  // receive lanes
  input  wire logic [LANES-1:0][7:0] LANE_RECEIVE_BYTE,
  input  wire logic [LANES-1:0]      LANE_RECEIVE_KCHAR_FLAG,
  input  wire logic [LANES-1:0][1:0] LANE_RECEIVE_STATUS,
  input  wire logic [LANES-1:0]      LANE_RECEIVE_VALID,
  input  wire logic [LANES-1:0]      LANE_RECEIVE_IDLE_DETECT,
  output logic      [LANES-1:0]      LANE_RECEIVE_INVERT,
  // transmit lanes
  output logic      [LANES-1:0][7:0] LANE_TRANSMIT_BYTE,
  output logic      [LANES-1:0]      LANE_TRANSMIT_KCHAR_FLAG,
  output logic      [LANES-1:0]      LANE_TRANSMIT_COMPLIANCE,
  output logic      [LANES-1:0]      LANE_TRANSMIT_IDLE_REQUEST
);

  // lane count is one or the full four
  generate
    if (LANES != 1 && LANES != PPP_MAX_LANES)
    begin : g_bad_lanes
      $error("ppp_port: LANES must be 1 or 4");
    end
  endgenerate

  // all state of the port
  typedef struct packed {
    logic                 pclk_s1;  // sync stage, read only by pclk_s2
    logic                 pclk_s2;
    logic                 pclk_s3;  // edge history
    logic                 lrst_s1;  // sync stage, read only by lrst_s2
    logic                 lrst_s2;  // high once link reset released
    logic                 done_s1;  // sync stage, read only by done_s2
    logic                 done_s2;
    logic                 done_s3;
    ppp_pwr_e             pwr_st;
    logic [1:0]           pwr_req;  // value asked by software
    logic [1:0]           pwr_pin;  // value on the pins
    logic                 done_flag;
    logic                 refused_flag;
    logic [LANES-1:0]     inv;
    logic [LANES-1:0]     cmp;
    logic [LANES-1:0]     idl;
    ppp_tx_s [LANES-1:0]  tx_word;
    logic [31:0]          rdata;
    logic                 slverr;
    logic                 txclk;
  } ppp_top_s;

  ppp_top_s q;  // registered state
  ppp_top_s d;  // next state

  // per-lane carriers
  ppp_rx_s [LANES-1:0] rx_pin;  // pins gathered per lane
  ppp_rx_s [LANES-1:0] rx_cap;  // captured receive words
  ppp_tx_s [LANES-1:0] tx_pin;  // launched transmit words

  // link timing strobes
  logic pclk_rise;  // PHY clock rising edge seen
  logic link_up;    // link reset released

  // bus phase decode
  logic       setup;    // first apb cycle
  logic       wr_take;  // write takes effect
  logic [1:0] lane_ix;  // lane of a per-lane register
  logic [3:0] region;   // upper address nibble

  // merge byte lanes of a write over the old value
  function automatic logic [31:0] ppp_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : ppp_merge

  // edge and phase decode
  assign pclk_rise = q.pclk_s2 & ~q.pclk_s3;
  assign link_up   = q.lrst_s2;
  assign setup     = PSEL & ~PENABLE;
  assign wr_take   = PSEL & PENABLE & PWRITE & ~q.slverr;
  assign lane_ix   = PADDR[3:2];
  assign region    = PADDR[7:4];

  // gather receive pins into lane words
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      rx_pin[i].data   = LANE_RECEIVE_BYTE[i];
      rx_pin[i].kchar  = LANE_RECEIVE_KCHAR_FLAG[i];
      rx_pin[i].status = LANE_RECEIVE_STATUS[i];
      rx_pin[i].valid  = LANE_RECEIVE_VALID[i];
      rx_pin[i].idle   = LANE_RECEIVE_IDLE_DETECT[i];
    end
  end

  // next-state logic
  always_comb
  begin
    logic [31:0] rd;       // read value for the addressed register
    logic        err;      // unmapped or illegal access
    logic [31:0] wv;       // merged write value
    logic [1:0]  new_pwr;  // power field of a control write
    rd      = '0;
    err     = 1'b0;
    wv      = '0;
    new_pwr = '0;
    d       = q;

    // synchronisers for pins from the PHY clock domain
    d.pclk_s1 = PHY_CLK;
    d.pclk_s2 = q.pclk_s1;
    d.pclk_s3 = q.pclk_s2;
    d.lrst_s1 = LINK_RST_N;
    d.lrst_s2 = q.lrst_s1;
    d.done_s1 = PHY_DONE;
    d.done_s2 = q.done_s1;
    d.done_s3 = q.done_s2;

    // transmit clock mid-eye: rises half a period after launch
    d.txclk = ~q.pclk_s2;

    // read decode in the setup phase, answered in the access phase
    if (setup)
    begin
      if (PADDR[1:0] != 2'h0)
      begin
        err = 1'b1;  // misaligned
      end
      else if (PADDR == PPP_CTRL_OFS)
      begin
        rd[PPP_CTRL_PWR_LSB +: 2] = q.pwr_req;
      end
      else if (PADDR == PPP_STATUS_OFS)
      begin
        rd[PPP_ST_BUSY]              = (q.pwr_st != PWR_IDLE);
        rd[PPP_ST_DONE]              = q.done_flag;
        rd[PPP_ST_REFUSED]           = q.refused_flag;
        rd[PPP_ST_LINK_RST]          = ~link_up;
        rd[PPP_ST_PWR_LSB +: 2]      = q.pwr_pin;
        rd[PPP_ST_PHYDONE]           = q.done_s3;
        for (int i = 0; i < LANES; i++)
        begin
          rd[PPP_ST_IDLE_LSB + i] = rx_cap[i].idle;
          rd[PPP_ST_VLD_LSB + i]  = rx_cap[i].valid;
        end
      end
      else if (PADDR == PPP_LANE_OFS)
      begin
        rd[PPP_LC_INV_LSB +: LANES]  = q.inv;
        rd[PPP_LC_CMP_LSB +: LANES]  = q.cmp;
        rd[PPP_LC_IDLE_LSB +: LANES] = q.idl;
      end
      else if (region == PPP_TX_REGION && int'(lane_ix) < LANES)
      begin
        rd[$bits(ppp_tx_s)-1:0] = q.tx_word[lane_ix];
      end
      else if (region == PPP_RX_REGION && int'(lane_ix) < LANES)
      begin
        rd[$bits(ppp_rx_s)-1:0] = rx_cap[lane_ix];
        err                     = PWRITE;  // capture is read-only
      end
      else
      begin
        err = 1'b1;  // absent lane or unmapped
      end
      d.rdata  = err ? 32'h0000_0000 : rd;
      d.slverr = err;
    end

    // write takes effect at the access edge
    if (wr_take)
    begin
      if (PADDR == PPP_CTRL_OFS)
      begin
        wv      = ppp_merge({30'h0000_0000, q.pwr_req}, PWDATA, PSTRB);
        new_pwr = wv[PPP_CTRL_PWR_LSB +: 2];
        if (q.pwr_st == PWR_IDLE)
        begin
          // a new state is sent; rewriting the present one does nothing
          if (new_pwr != q.pwr_pin)
          begin
            d.pwr_req = new_pwr;
            d.pwr_st  = PWR_LAUNCH;
          end
        end
        else if (new_pwr != q.pwr_req)
        begin
          d.refused_flag = 1'b1;
        end
      end
      else if (PADDR == PPP_STATUS_OFS)
      begin
        // write one to clear; a same-cycle set below wins
        if (PSTRB[0] && PWDATA[PPP_ST_DONE])
        begin
          d.done_flag = 1'b0;
        end
        if (PSTRB[0] && PWDATA[PPP_ST_REFUSED])
        begin
          d.refused_flag = 1'b0;
        end
      end
      else if (PADDR == PPP_LANE_OFS)
      begin
        wv    = ppp_merge(q.rdata, PWDATA, PSTRB);
        d.inv = wv[PPP_LC_INV_LSB +: LANES];
        d.cmp = wv[PPP_LC_CMP_LSB +: LANES];
        d.idl = wv[PPP_LC_IDLE_LSB +: LANES];
      end
      else if (region == PPP_TX_REGION)
      begin
        wv                  = ppp_merge(q.rdata, PWDATA, PSTRB);
        d.tx_word[lane_ix]  = wv[$bits(ppp_tx_s)-1:0];
      end
    end

    // power request sequencer, stepped by PHY clock edges
    case (q.pwr_st)
      PWR_IDLE:
      begin
        // nothing outstanding
      end
      PWR_LAUNCH:
      begin
        if (pclk_rise)
        begin
          d.pwr_pin = q.pwr_req;
          d.pwr_st  = PWR_WAIT;
        end
      end
      PWR_WAIT:
      begin
        // pins held until the PHY reports completion
        if (pclk_rise && q.done_s3)
        begin
          d.pwr_st    = PWR_IDLE;
          d.done_flag = 1'b1;
        end
      end
      default:
      begin
        d.pwr_st = PWR_IDLE;
      end
    endcase

    // link reset overrides the sequencer and the pins
    if (!link_up)
    begin
      d.pwr_st  = PWR_IDLE;
      d.pwr_pin = PPP_PWR_RST;
      d.pwr_req = PPP_PWR_RST;
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      q         <= '0;
      q.pwr_st  <= PWR_IDLE;
      q.pwr_pin <= PPP_PWR_RST;
      q.pwr_req <= PPP_PWR_RST;
      q.idl     <= {LANES{PPP_TX_IDLE_RST}};
    end
    else if (CLK_EN)
    begin
      q <= d;
    end
  end

  // one lane engine per configured lane
  generate
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
      ppp_lane u_lane (
        .clk        (CORE_CLK),
        .rst        (SYS_RST),
        .ce         (CLK_EN),
        .link_up    (link_up),
        .pclk_rise  (pclk_rise),
        .tx_word    (q.tx_word[g]),
        .invert     (q.inv[g]),
        .compliance (q.cmp[g]),
        .idle_req   (q.idl[g]),
        .rx_cap     (rx_cap[g]),
        .rx_pin     (rx_pin[g]),
        .tx_pin     (tx_pin[g]),
        .invert_pin (LANE_RECEIVE_INVERT[g]),
        .compl_pin  (LANE_TRANSMIT_COMPLIANCE[g]),
        .idle_pin   (LANE_TRANSMIT_IDLE_REQUEST[g])
      );
      assign LANE_TRANSMIT_BYTE[g]       = tx_pin[g].data;
      assign LANE_TRANSMIT_KCHAR_FLAG[g] = tx_pin[g].kchar;
    end
  endgenerate

  // apb answers: no wait states, data from flip-flops
  assign PREADY  = 1'b1;
  assign PRDATA  = q.rdata;
  assign PSLVERR = PSEL & PENABLE & q.slverr;

  // shared link outputs
  assign POWER_REQUEST = q.pwr_pin;
  assign TX_CLK_OUT    = HAS_TXCLK ? q.txclk : 1'b0;

endmodule : ppp_port

// ---- test/ppp_port_chk.sv ----
// assertion checker for the PHY lane port, bound to its top module
`timescale 1ns/100ps
module ppp_port_chk
  import ppp_pkg::*;
#(
  parameter int LANES = 4  // lane count of the port
)
(
  // clock and reset
  input wire logic                  CORE_CLK,
  input wire logic                  SYS_RST,
  // apb
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic [PPP_ADDR_W-1:0] PADDR,
  input wire logic [31:0]           PRDATA,
  input wire logic                  PSLVERR,
  // link
  input wire logic                  PHY_CLK,
  input wire logic                  LINK_RST_N,
  input wire logic [1:0]            POWER_REQUEST,
  input wire logic                  TX_CLK_OUT,
  input wire logic [LANES-1:0][7:0] LANE_TRANSMIT_BYTE,
  input wire logic [LANES-1:0]      LANE_TRANSMIT_COMPLIANCE,
  input wire logic [LANES-1:0]      LANE_TRANSMIT_IDLE_REQUEST
);
  logic [2:0] up_q;  // cycles since reset, saturating: keeps $past clear of reset
  // count up after reset release
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
    if (SYS_RST)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  // link reset seen long enough to pass the synchroniser
  sequence s_link_held;
    !LINK_RST_N [*4];
  endsequence
  // a transmit byte launch outside link reset
  sequence s_tx_launch;
    $changed(LANE_TRANSMIT_BYTE) && LINK_RST_N;
  endsequence
  a_txclk_follow: assert property (up_q == 3'h7 |-> TX_CLK_OUT == !$past(PHY_CLK, 3))
    else $error("transmit clock not inverted delayed link clock");
  a_tx_eye: assert property ($rose(TX_CLK_OUT) |-> $stable(LANE_TRANSMIT_BYTE))
    else $error("transmit byte moved at transmit clock rise");
  a_tx_hold: assert property (s_tx_launch |=> $stable(LANE_TRANSMIT_BYTE) [*6])
    else $error("transmit byte held less than a link period");
  a_pwr_hold: assert property ($changed(POWER_REQUEST) && LINK_RST_N |=>
    $stable(POWER_REQUEST) [*8])
    else $error("power request changed again too soon");
  a_ctl_launch: assert property (($changed(POWER_REQUEST) || $changed(LANE_TRANSMIT_IDLE_REQUEST)
    || $changed(LANE_TRANSMIT_COMPLIANCE)) && LINK_RST_N |-> !TX_CLK_OUT)
    else $error("control launched away from link clock rise");
  a_link_reset: assert property (s_link_held |-> POWER_REQUEST == PPP_PWR_RST &&
    &LANE_TRANSMIT_IDLE_REQUEST && LANE_TRANSMIT_COMPLIANCE == '0 && LANE_TRANSMIT_BYTE == '0)
    else $error("link reset did not restore lane outputs");
  a_core_reset: assert property (disable iff (1'b0) SYS_RST |->
    POWER_REQUEST == PPP_PWR_RST && &LANE_TRANSMIT_IDLE_REQUEST && !TX_CLK_OUT)
    else $error("reset values wrong on link outputs");
  a_err_phase: assert property (PSLVERR |-> PSEL && PENABLE && PRDATA == 32'h0)
    else $error("error response outside access or with data");
  a_err_align: assert property (PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("misaligned access not refused");
endmodule : ppp_port_chk
bind ppp_port ppp_port_chk #(.LANES(LANES)) i_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .PHY_CLK(PHY_CLK), .LINK_RST_N(LINK_RST_N), .POWER_REQUEST(POWER_REQUEST),
  .TX_CLK_OUT(TX_CLK_OUT), .LANE_TRANSMIT_BYTE(LANE_TRANSMIT_BYTE),
  .LANE_TRANSMIT_COMPLIANCE(LANE_TRANSMIT_COMPLIANCE),
  .LANE_TRANSMIT_IDLE_REQUEST(LANE_TRANSMIT_IDLE_REQUEST));

// ---- test/ppp_phy_model.sv ----
// behavioural PHY partner: link clock, receive lanes, power completion
`timescale 1ns/100ps
module ppp_phy_model
  import ppp_pkg::*;
(
  // toward the port
  output logic            phy_clk,
  output logic            phy_done,
  output logic [3:0][7:0] rx_byte,
  output logic [3:0]      rx_k,
  output logic [3:0][1:0] rx_stat,
  output logic [3:0]      rx_vld,
  output logic [3:0]      rx_idle,
  // from the port and the bench
  input  wire logic [1:0] power_req,
  input  wire logic [3:0] done_lat,
  input  wire ppp_rx_s [3:0] rx_cmd
);
  logic [1:0] seen_q;  // last request acted on
  logic [3:0] cnt_q;   // link clocks left before completion
  // free-running link clock, phase unrelated to the core clock
  initial
  begin
    phy_clk = 1'b0;
    phy_done = 1'b0;
    {rx_byte, rx_k, rx_stat, rx_vld, rx_idle} = '0;
    seen_q = PPP_PWR_RST;
    cnt_q = 4'h0;
    #7;
    // stands in for the 250 or 125 MHz clock, slowed so core sampling finds edges
    forever #24 phy_clk = ~phy_clk;
  end
  // launch receive words and completion on the link clock rise
  always @(posedge phy_clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      rx_byte[i] <= rx_cmd[i].data;
      rx_k[i] <= rx_cmd[i].kchar;
      rx_stat[i] <= rx_cmd[i].status;
      rx_vld[i] <= rx_cmd[i].valid;
      rx_idle[i] <= rx_cmd[i].idle;
    end
    // new request: completion after a bench-chosen delay, prompt or slow
    if (power_req != seen_q)
    begin
      seen_q <= power_req;
      cnt_q <= done_lat;
      phy_done <= 1'b0;
    end
    else if (cnt_q != 4'h0)
    begin
      cnt_q <= cnt_q - 4'h1;
      phy_done <= (cnt_q == 4'h1);
    end
    else
      phy_done <= 1'b0;  // one link period only
  end
endmodule : ppp_phy_model

// ---- test/ppp_port_tb.sv ----
// self-checking bench for the PHY lane port
`timescale 1ns/100ps
module ppp_port_tb
  import ppp_pkg::*;
;
  logic clk, rst, link_n, psel, penable, pwrite, pready, pslverr, err;  // apb and resets
  logic [7:0]      paddr;                              // byte address
  logic [31:0]     pwdata, prdata, rd;                 // write, read, last read
  logic            phy_clk, phy_done, txclk;           // link shared
  logic [1:0]      pwr;                                // power request pins
  logic [3:0]      done_lat, rx_k, rx_v, rx_i, inv, tx_k, cmp, idl;  // completion delay and per lane bits
  logic [3:0][7:0] rx_b, tx_b;                         // lane bytes
  logic [3:0][1:0] rx_s;                               // lane status
  ppp_rx_s [3:0]   rx_cmd;                             // words the partner sends
  logic [1:0]      pw_seq [4] = '{2'h3, 2'h0, 2'h1, 2'h2};  // every power code
  logic [7:0]      bad_a [3] = '{8'h02, 8'h30, 8'h20};      // refused places
  int              n_mismatch, cmp_count;
  ppp_port #(.LANES(4), .HAS_TXCLK(1'b1)) i_dut (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(1'b1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PHY_CLK(phy_clk),
    .LINK_RST_N(link_n), .PHY_DONE(phy_done), .POWER_REQUEST(pwr), .TX_CLK_OUT(txclk),
    .LANE_RECEIVE_BYTE(rx_b), .LANE_RECEIVE_KCHAR_FLAG(rx_k), .LANE_RECEIVE_STATUS(rx_s),
    .LANE_RECEIVE_VALID(rx_v), .LANE_RECEIVE_IDLE_DETECT(rx_i), .LANE_RECEIVE_INVERT(inv),
    .LANE_TRANSMIT_BYTE(tx_b), .LANE_TRANSMIT_KCHAR_FLAG(tx_k),
    .LANE_TRANSMIT_COMPLIANCE(cmp), .LANE_TRANSMIT_IDLE_REQUEST(idl));
  ppp_phy_model i_phy (.phy_clk(phy_clk), .phy_done(phy_done), .rx_byte(rx_b), .rx_k(rx_k),
    .rx_stat(rx_s), .rx_vld(rx_v), .rx_idle(rx_i), .power_req(pwr), .done_lat(done_lat),
    .rx_cmd(rx_cmd));
  // core clock, 5 ns
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // one apb transfer; hold skips the release so a setup may follow at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic hold);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    if (!hold)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb
  // compare one value
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // let n link clock rises pass, then the synchroniser settle
  task automatic pwait(input int n);
    repeat (n) @(posedge phy_clk);
    repeat (4) @(posedge clk);
  endtask : pwait
  // print counts and verdict, end the run
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  // watchdog against a hang
  initial
  begin
    #20000;
    n_mismatch++;
    results();
  end
  // main sequence
  initial
  begin
    {rst, link_n, psel, penable, pwrite, paddr, pwdata, done_lat, rx_cmd} = '0;
    rst = 1'b1;
    link_n = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset pins", 32'h2F, {26'h0, pwr, idl});
    apb(1'b0, PPP_LANE_OFS, 32'h0, 1'b0);
    chk("lane ctrl reset", 32'h0F00, rd);
    // transmit words and lane controls on every lane
    for (int i = 0; i < 4; i++)
      apb(1'b1, 8'h10 + 8'(4 * i), {23'h0, 8'h5A ^ 8'(i * 17), i[0]}, 1'b0);
    apb(1'b1, PPP_LANE_OFS, 32'h035A, 1'b0);
    pwait(2);
    for (int i = 0; i < 4; i++)
      chk("tx lane", {23'h0, 8'h5A ^ 8'(i * 17), i[0]}, {23'h0, tx_b[i], tx_k[i]});
    chk("lane pins", 32'h35A, {20'h0, idl, cmp, inv});
    // receive words on every lane
    for (int i = 0; i < 4; i++)
      rx_cmd[i] <= {8'hC0 | 8'(i), i[0], 2'(i), 1'b1, i[1]};
    pwait(3);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'h20 + 8'(4 * i), 32'h0, 1'b0);
      chk("rx lane", {19'h0, rx_cmd[i]}, rd);
    end
    apb(1'b0, PPP_STATUS_OFS, 32'h0, 1'b0);
    chk("rx flags", 32'hFC, 32'(rd[15:8]));
    // every power code, a refused overwrite while busy, prompt to slow completion
    for (int k = 0; k < 4; k++)
    begin
      done_lat <= 4'(k + 1);
      apb(1'b1, PPP_CTRL_OFS, 32'(pw_seq[k]), 1'b1);
      apb(1'b1, PPP_CTRL_OFS, 32'(pw_seq[k] ^ 2'h1), 1'b0);
      pwait(2);
      chk("power pins", 32'(pw_seq[k]), 32'(pwr));
      // still waiting on completion: busy, refused, pins shown, pending kept
      apb(1'b0, PPP_STATUS_OFS, 32'h0, 1'b0);
      chk("power busy", {26'h0, pw_seq[k], 4'h5}, 32'(rd[5:0]));
      apb(1'b0, PPP_CTRL_OFS, 32'h0, 1'b0);
      chk("power pending", 32'(pw_seq[k]), rd);
      pwait(k + 4);
      apb(1'b0, PPP_STATUS_OFS, 32'h0, 1'b0);
      chk("power status", 32'h6, 32'(rd[2:0]));
      apb(1'b1, PPP_STATUS_OFS, 32'h6, 1'b0);
      apb(1'b0, PPP_STATUS_OFS, 32'h0, 1'b0);
      chk("status cleared", 32'h0, 32'(rd[2:0]));
    end
    // misaligned, unmapped, and a write to a capture word
    for (int j = 0; j < 3; j++)
    begin
      apb(j == 2, bad_a[j], 32'hFFFF, 1'b0);
      chk("refused access", 32'h1, 32'(err));
    end
    // link reset in mid-run, then relaunch
    link_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk("link reset pins", 32'h2F, {26'h0, pwr, idl});
    apb(1'b0, PPP_STATUS_OFS, 32'h0, 1'b0);
    chk("link reset flag", 32'h1, 32'(rd[3]));
    link_n <= 1'b1;
    pwait(3);
    chk("relaunch", 32'h35A, {20'h0, idl, cmp, inv});
    chk("relaunch byte", 32'h5A, 32'(tx_b[0]));
    results();
  end
endmodule : ppp_port_tb
